// file: common/scsc_pkg.sv
package scsc_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BAUD_BPS = 19200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] CMD_PORT_FIRST = 8'h10;
  localparam logic [7:0] CMD_PORT_LAST = 8'h1F;
  localparam logic [7:0] CMD_VIDEO_OFF = 8'h71;
  localparam logic [4:0] CHAN_OFF = 5'h00;
  localparam logic [4:0] CHAN_RESET = 5'h00;
  localparam logic [3:0] DIGIT_LIMIT = 4'h9;
  typedef enum logic {SCSC_MODE_POWER, SCSC_MODE_LOCKSTEP} scsc_mode_type;
endpackage : scsc_pkg

// file: common/scsc_link_if.sv
`timescale 1ns/100ps
interface scsc_link_if;
  logic to_switch;
  logic to_remote;
  modport switch_end (input to_switch, output to_remote);
  modport remote_end (output to_switch, input to_remote);
endinterface : scsc_link_if

// file: core/scsc_switch.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Link runs at 19200 bits per second
// - Eight data bits, no parity bit
// - No flow control on the link
// - Echo each valid received command byte in lockstep mode; a later send replaces it while it is still pending
// - Received byte alone picks the host port
// - 10h-1Fh pick ports 1-16; 71h video off
// - In lockstep mode a channel change sends its command byte; a later send replaces it while it is still pending
// - Received command switches channel; slaves follow
// - Switching by received command only in lockstep mode; local and cascade selects work in both modes
// - Port mode: power control or lockstep
// - Cascade address: two decimal digits per level
module scsc_switch (
  input wire logic clk_sys,
  input wire logic reset,
  scsc_link_if.switch_end link,
  input wire logic mode_lockstep,
  input wire logic local_sel_valid,
  input wire logic [4:0] local_sel_chan,
  input wire logic [3:0] casc_digit_0,
  input wire logic [3:0] casc_digit_1,
  input wire logic [3:0] casc_digit_2,
  input wire logic [3:0] casc_digit_3,
  input wire logic casc_two_level,
  input wire logic casc_valid,
  output logic [4:0] chan_q,
  output logic [4:0] casc_lower_chan_q,
  output logic casc_addr_err_q,
  output logic power_port_active_q
);
  function automatic logic cmd_ok(input logic [7:0] b);
    cmd_ok = (b >= scsc_pkg::CMD_PORT_FIRST && b <= scsc_pkg::CMD_PORT_LAST)
      || b == scsc_pkg::CMD_VIDEO_OFF;
  endfunction : cmd_ok

  function automatic logic [4:0] cmd_to_chan(input logic [7:0] b);
    cmd_to_chan = (b == scsc_pkg::CMD_VIDEO_OFF) ? scsc_pkg::CHAN_OFF
      : 5'(b[3:0]) + 5'h01;
  endfunction : cmd_to_chan

  function automatic logic [7:0] chan_to_cmd(input logic [4:0] c);
    chan_to_cmd = (c == scsc_pkg::CHAN_OFF) ? scsc_pkg::CMD_VIDEO_OFF
      : scsc_pkg::CMD_PORT_FIRST + 8'(c - 5'h01);
  endfunction : chan_to_cmd

  function automatic logic [4:0] digits_to_port(input logic [3:0] hi, input logic [3:0] lo);
    logic [7:0] v;
    v = 8'(hi) * 8'h0A + 8'(lo);
    digits_to_port = (hi > scsc_pkg::DIGIT_LIMIT || lo > scsc_pkg::DIGIT_LIMIT
      || v == 8'h00 || v > 8'h10) ? 5'h1F : v[4:0];
  endfunction : digits_to_port

  // Synchroniser on the serial input
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= link.to_switch;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Receiver: start, 8 data, stop; no parity, no handshake
  typedef enum logic [1:0] {SCSC_RX_IDLE, SCSC_RX_START, SCSC_RX_DATA, SCSC_RX_STOP} scsc_rx_type;
  scsc_rx_type rx_st_q;
  logic [12:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_done_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_st_q <= SCSC_RX_IDLE;
      rx_cnt_q <= 13'h0000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_st_q)
        SCSC_RX_IDLE: begin
          if (!rx_s2_q) begin
            rx_st_q <= SCSC_RX_START;
            rx_cnt_q <= 13'(scsc_pkg::HALF_CYCLES - 1);
          end
        end
        SCSC_RX_START: begin
          if (rx_cnt_q != 13'h0000) begin
            rx_cnt_q <= rx_cnt_q - 13'h0001;
          end else if (rx_s2_q) begin
            rx_st_q <= SCSC_RX_IDLE; // Glitch, not a start bit
          end else begin
            rx_st_q <= SCSC_RX_DATA;
            rx_cnt_q <= 13'(scsc_pkg::BIT_CYCLES - 1);
            rx_bit_q <= 3'h0;
          end
        end
        SCSC_RX_DATA: begin
          if (rx_cnt_q != 13'h0000) begin
            rx_cnt_q <= rx_cnt_q - 13'h0001;
          end else begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
            rx_cnt_q <= 13'(scsc_pkg::BIT_CYCLES - 1);
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'(scsc_pkg::DATA_BITS - 1)) begin
              rx_st_q <= SCSC_RX_STOP;
            end
          end
        end
        SCSC_RX_STOP: begin
          if (rx_cnt_q != 13'h0000) begin
            rx_cnt_q <= rx_cnt_q - 13'h0001;
          end else begin
            rx_st_q <= SCSC_RX_IDLE;
            rx_done_q <= rx_s2_q; // Framing error drops the byte
          end
        end
        default: rx_st_q <= SCSC_RX_IDLE;
      endcase
    end
  end

  // Mode strap, one use at a time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_port_active_q <= 1'b1;
    end else begin
      power_port_active_q <= !mode_lockstep;
    end
  end

  // Cascade address decode
  logic [4:0] top_port, low_port;
  always_comb begin
    top_port = digits_to_port(casc_digit_0, casc_digit_1);
    low_port = casc_two_level ? digits_to_port(casc_digit_2, casc_digit_3) : scsc_pkg::CHAN_OFF;
  end
  logic casc_bad;
  always_comb begin
    casc_bad = top_port == 5'h1F || low_port == 5'h1F;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      casc_lower_chan_q <= scsc_pkg::CHAN_RESET;
      casc_addr_err_q <= 1'b0;
    end else if (casc_valid) begin
      casc_addr_err_q <= casc_bad;
      if (!casc_bad) begin
        casc_lower_chan_q <= low_port;
      end
    end
  end

  // Channel selection; a received command wins over a local one
  logic rx_take, new_chg;
  logic [4:0] new_chan;
  always_comb begin
    rx_take = rx_done_q && cmd_ok(rx_sh_q) && !power_port_active_q;
    new_chan = chan_q;
    new_chg = 1'b0;
    if (rx_take) begin
      new_chan = cmd_to_chan(rx_sh_q);
      new_chg = 1'b1;
    end else if (casc_valid && !casc_bad) begin
      new_chan = top_port;
      new_chg = 1'b1;
    end else if (local_sel_valid && local_sel_chan <= 5'h10) begin
      new_chan = local_sel_chan;
      new_chg = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chan_q <= scsc_pkg::CHAN_RESET;
    end else if (new_chg) begin
      chan_q <= new_chan;
    end
  end

  // Transmit request: echo, or announce a change
  logic tx_pend_q;
  logic [7:0] tx_byte_q;
  logic tx_busy;
  logic send_req;
  always_comb begin
    send_req = (rx_take || (new_chg && new_chan != chan_q)) && !power_port_active_q;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_pend_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else if (send_req) begin
      tx_pend_q <= 1'b1; // Latest wins; no flow control to hold it off
      tx_byte_q <= rx_take ? rx_sh_q : chan_to_cmd(new_chan);
    end else if (!tx_busy) begin
      tx_pend_q <= 1'b0;
    end
  end

  // Transmitter: 10 bit frame, no handshake
  logic [12:0] tx_cnt_q;
  logic [3:0] tx_idx_q;
  logic [9:0] tx_fr_q;
  assign tx_busy = tx_idx_q != 4'h0;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_cnt_q <= 13'h0000;
      tx_idx_q <= 4'h0;
      tx_fr_q <= 10'h3FF;
      link.to_remote <= 1'b1;
    end else if (!tx_busy) begin
      link.to_remote <= 1'b1;
      if (tx_pend_q) begin
        tx_fr_q <= {1'b1, tx_byte_q, 1'b0};
        tx_idx_q <= 4'hB; // Extra slot keeps a full stop bit between frames
        tx_cnt_q <= 13'h0000;
      end
    end else if (tx_cnt_q != 13'h0000) begin
      tx_cnt_q <= tx_cnt_q - 13'h0001;
    end else begin
      link.to_remote <= tx_fr_q[0];
      tx_fr_q <= {1'b1, tx_fr_q[9:1]};
      tx_cnt_q <= 13'(scsc_pkg::BIT_CYCLES - 1);
      tx_idx_q <= tx_idx_q - 4'h1;
    end
  end
endmodule : scsc_switch

// file: core/scsc_remote.sv
`timescale 1ns/100ps
module scsc_remote (
  input wire logic clk_sys,
  input wire logic reset,
  scsc_link_if.remote_end link,
  input wire logic send_valid,
  input wire logic [7:0] send_byte,
  output logic send_ready_q,
  output logic echo_valid_q,
  output logic [7:0] echo_byte_q
);
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= link.to_remote;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Receiver of echoes and announcements
  logic [12:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_sh_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_cnt_q <= 13'h0000;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h000;
      echo_valid_q <= 1'b0;
      echo_byte_q <= 8'h00;
    end else begin
      echo_valid_q <= 1'b0;
      if (rx_idx_q == 4'h0) begin
        if (!rx_s2_q) begin
          rx_idx_q <= 4'hA;
          rx_cnt_q <= 13'(scsc_pkg::HALF_CYCLES - 1);
        end
      end else if (rx_cnt_q != 13'h0000) begin
        rx_cnt_q <= rx_cnt_q - 13'h0001;
      end else begin
        rx_cnt_q <= 13'(scsc_pkg::BIT_CYCLES - 1);
        rx_idx_q <= rx_idx_q - 4'h1;
        rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
        if (rx_idx_q == 4'hA && rx_s2_q) begin
          rx_idx_q <= 4'h0;
        end
        if (rx_idx_q == 4'h1) begin
          echo_valid_q <= rx_s2_q;
          echo_byte_q <= rx_sh_q[8:1];
        end
      end
    end
  end

  // Transmitter; send_ready is local pacing, never a line handshake
  logic [12:0] tx_cnt_q;
  logic [3:0] tx_idx_q;
  logic [9:0] tx_fr_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_cnt_q <= 13'h0000;
      tx_idx_q <= 4'h0;
      tx_fr_q <= 10'h3FF;
      link.to_switch <= 1'b1;
      send_ready_q <= 1'b0;
    end else if (tx_idx_q == 4'h0) begin
      link.to_switch <= 1'b1;
      send_ready_q <= !(send_valid && send_ready_q);
      if (send_valid && send_ready_q) begin
        tx_fr_q <= {1'b1, send_byte, 1'b0};
        tx_idx_q <= 4'hB; // Extra slot keeps a full stop bit between frames
        tx_cnt_q <= 13'h0000;
      end
    end else if (tx_cnt_q != 13'h0000) begin
      tx_cnt_q <= tx_cnt_q - 13'h0001;
    end else begin
      link.to_switch <= tx_fr_q[0];
      tx_fr_q <= {1'b1, tx_fr_q[9:1]};
      tx_cnt_q <= 13'(scsc_pkg::BIT_CYCLES - 1);
      tx_idx_q <= tx_idx_q - 4'h1;
    end
  end
endmodule : scsc_remote

// file: dv/scsc_assertions.sv
`timescale 1ns/100ps
module scsc_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic to_switch,
  input wire logic to_remote
);
  localparam int BIT = scsc_pkg::BIT_CYCLES;
  localparam int FRAME = 10 * BIT;
  logic [15:0] rcnt_q;
  logic [15:0] scnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Frame position from the start edge; both lines share the same framing
  always_ff @(posedge clk_sys) begin
    if (reset || rcnt_q == 16'(FRAME - 1)) rcnt_q <= 16'h0000;
    else if (rcnt_q != 16'h0000 || !to_remote) rcnt_q <= rcnt_q + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    if (reset || scnt_q == 16'(FRAME - 1)) scnt_q <= 16'h0000;
    else if (scnt_q != 16'h0000 || !to_switch) scnt_q <= scnt_q + 16'h0001;
  end
  property p_idle_r; $fell(reset) |-> to_remote; endproperty
  a_idle_r: assert property (p_idle_r) else $error("reply line not idle after reset");
  property p_idle_s; $fell(reset) |-> to_switch; endproperty
  a_idle_s: assert property (p_idle_s) else $error("command line not idle after reset");
  property p_start_r; (rcnt_q > 0 && rcnt_q < BIT) |-> !to_remote; endproperty
  a_start_r: assert property (p_start_r) else $error("reply start bit too short");
  property p_start_s; (scnt_q > 0 && scnt_q < BIT) |-> !to_switch; endproperty
  a_start_s: assert property (p_start_s) else $error("command start bit too short");
  // Stop right after eight data bits means no parity slot
  property p_stop_r; (rcnt_q >= 9 * BIT) |-> to_remote; endproperty
  a_stop_r: assert property (p_stop_r) else $error("reply stop bit missing");
  property p_stop_s; (scnt_q >= 9 * BIT) |-> to_switch; endproperty
  a_stop_s: assert property (p_stop_s) else $error("command stop bit missing");
  property p_hold_r; (rcnt_q > 0 && rcnt_q % BIT != 0) |-> $stable(to_remote); endproperty
  a_hold_r: assert property (p_hold_r) else $error("reply line moved inside a bit");
  property p_hold_s; (scnt_q > 0 && scnt_q % BIT != 0) |-> $stable(to_switch); endproperty
  a_hold_s: assert property (p_hold_s) else $error("command line moved inside a bit");
endmodule : scsc_assertions

// file: dv/serial_channel_switch_control_tb.sv
`timescale 1ns/100ps
module serial_channel_switch_control_tb;
  logic clk_sys, reset, mode_lockstep, local_sel_valid, casc_two_level, casc_valid;
  logic send_valid, casc_addr_err_q, power_port_active_q, send_ready_q, echo_valid_q;
  logic [4:0] local_sel_chan, chan_q, casc_lower_chan_q;
  logic [3:0] casc_digit_0, casc_digit_1, casc_digit_2, casc_digit_3;
  logic [7:0] send_byte, echo_byte_q, cmd;
  int error_cnt, n_tests, i, r, lc;
  scsc_link_if link();
  scsc_switch scsc_switch_i (.clk_sys(clk_sys), .reset(reset), .link(link),
    .mode_lockstep(mode_lockstep), .local_sel_valid(local_sel_valid),
    .local_sel_chan(local_sel_chan), .casc_digit_0(casc_digit_0), .casc_digit_1(casc_digit_1),
    .casc_digit_2(casc_digit_2), .casc_digit_3(casc_digit_3), .casc_two_level(casc_two_level),
    .casc_valid(casc_valid), .chan_q(chan_q), .casc_lower_chan_q(casc_lower_chan_q),
    .casc_addr_err_q(casc_addr_err_q), .power_port_active_q(power_port_active_q));
  scsc_remote scsc_remote_i (.clk_sys(clk_sys), .reset(reset), .link(link),
    .send_valid(send_valid), .send_byte(send_byte), .send_ready_q(send_ready_q),
    .echo_valid_q(echo_valid_q), .echo_byte_q(echo_byte_q));
  scsc_assertions scsc_assertions_i (.clk_sys(clk_sys), .reset(reset),
    .to_switch(link.to_switch), .to_remote(link.to_remote));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] cmd_of(input int c);
    return (c == 0) ? scsc_pkg::CMD_VIDEO_OFF : 8'(8'h0F + c);
  endfunction : cmd_of
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic limit(input int n);
    if (n >= 60000) begin
      error_cnt++;
      wrap_up();
    end
  endtask : limit
  task automatic local_sel(input logic [4:0] c);
    @(posedge clk_sys);
    local_sel_chan <= c;
    local_sel_valid <= 1'b1;
    @(posedge clk_sys);
    local_sel_valid <= 1'b0;
    @(negedge clk_sys);
  endtask : local_sel
  task automatic casc(input logic [15:0] dig, input logic two);
    @(posedge clk_sys);
    {casc_digit_0, casc_digit_1, casc_digit_2, casc_digit_3} <= dig;
    casc_two_level <= two;
    casc_valid <= 1'b1;
    @(posedge clk_sys);
    casc_valid <= 1'b0;
    @(negedge clk_sys);
  endtask : casc
  initial begin
    {mode_lockstep, local_sel_valid, casc_two_level, casc_valid, send_valid} = 5'h00;
    {casc_digit_0, casc_digit_1, casc_digit_2, casc_digit_3} = 16'h0000;
    local_sel_chan = 5'h00;
    send_byte = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    reset = 1'b1;
    r = $urandom(90);
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk({3'h0, chan_q}, 8'h00);
    chk({7'h00, power_port_active_q}, 8'h01);
    // Power mode: local and cascade selects still work, line stays silent
    r = $urandom_range(16, 1);
    local_sel(5'(r));
    chk({3'h0, chan_q}, 8'(r));
    casc(16'h1203, 1'b1);
    chk({3'h0, chan_q}, 8'h0C);
    chk({3'h0, casc_lower_chan_q}, 8'h03);
    chk({7'h00, casc_addr_err_q}, 8'h00);
    casc(16'h0A00, 1'b0);
    chk({7'h00, casc_addr_err_q}, 8'h01);
    chk({3'h0, chan_q}, 8'h0C);
    casc(16'h0700, 1'b0);
    chk({3'h0, chan_q}, 8'h07);
    chk({3'h0, casc_lower_chan_q}, 8'h00);
    local_sel(5'h11);
    chk({3'h0, chan_q}, 8'h07);
    @(posedge clk_sys);
    mode_lockstep <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, power_port_active_q}, 8'h00);
    // Late enough that a frame sent in power mode would show its start bit
    chk({7'h00, link.to_remote}, 8'h01);
    // Local change announced while a remote command is in flight
    lc = $urandom_range(16, 1);
    if (lc == 7) lc = 0;
    r = $urandom_range(16, 0);
    if (r == lc) r = 7;
    cmd = cmd_of(r);
    chk({7'h00, send_ready_q}, 8'h01);
    local_sel(5'(lc));
    chk({3'h0, chan_q}, 8'(lc));
    @(posedge clk_sys);
    send_byte <= cmd;
    send_valid <= 1'b1;
    @(posedge clk_sys);
    send_valid <= 1'b0;
    for (i = 0; i < 60000 && echo_valid_q !== 1'b1; i++) @(negedge clk_sys);
    limit(i);
    chk(echo_byte_q, cmd_of(lc));
    for (i = 0; i < 60000 && chan_q !== 5'(r); i++) @(negedge clk_sys);
    limit(i);
    chk({3'h0, chan_q}, 8'(r));
    // Echo queues behind the announcement, back to back
    @(negedge clk_sys);
    for (i = 0; i < 60000 && echo_valid_q !== 1'b1; i++) @(negedge clk_sys);
    limit(i);
    chk(echo_byte_q, cmd);
    wrap_up();
  end
endmodule : serial_channel_switch_control_tb
